// ===== design/tcir_pkg.sv
// Constants and types of the timer control and interrupt mask register bank
package tcir_pkg;
	// ==========================================================
	// Register port
	localparam int unsigned ADDR_W    = 6;
	localparam int unsigned DATA_W    = 8;
	localparam logic [5:0]  ADDR_CTRL = 6'h11;
	localparam logic [5:0]  ADDR_GPHI = 6'h12;
	localparam logic [5:0]  ADDR_GPLO = 6'h13;
	localparam logic [5:0]  ADDR_MMAI = 6'h14;
	localparam logic [5:0]  ADDR_MTIM = 6'h15;
	localparam logic [5:0]  ADDR_MERR = 6'h16;
	localparam logic [5:0]  ADDR_SMAI = 6'h17;
	localparam logic [5:0]  ADDR_STIM = 6'h18;
	localparam logic [5:0]  ADDR_SERR = 6'h19;
	// ==========================================================
	// Reset values and writable bits
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [7:0]  GP_RST      = 8'h00;
	localparam logic [7:0]  MASK_RST    = 8'h00;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;
	localparam logic [7:0]  CTRL_WMASK  = 8'hE3;
	localparam logic [7:0]  MMAI_WMASK  = 8'hFC;
	// ==========================================================
	// Field positions
	localparam int unsigned TRIG_MSB     = 7;
	localparam int unsigned TRIG_LSB     = 5;
	localparam int unsigned NRT_MODE_BIT = 1;
	localparam int unsigned NRT_STEP_BIT = 0;
	localparam int unsigned MAIN_SRC_LSB = 2;
	localparam int unsigned SUM_TIM_BIT  = 1;
	localparam int unsigned SUM_ERR_BIT  = 0;
	// ==========================================================
	// Timer scaling, in carrier periods and nanoseconds
	localparam int unsigned GP_STEP_FC      = 8;
	localparam int unsigned NRT_STEP_FC_S   = 64;
	localparam int unsigned NRT_STEP_FC_L   = 4096;
	localparam int unsigned GP_STEP_NS      = 590;
	localparam int unsigned CLK_PERIOD_NS   = 25;
	localparam int unsigned GP_STEP_CYC     = GP_STEP_NS / CLK_PERIOD_NS;
	localparam logic [15:0] GP_MIN_COUNT    = 16'h0001;
	localparam logic [15:0] GP_ZERO         = 16'h0000;
	// ==========================================================
	// Trigger sources
	typedef enum logic [2:0] {
		TRIG_NONE     = 3'b000,
		TRIG_RX_END   = 3'b001,
		TRIG_RX_START = 3'b010,
		TRIG_TX_END   = 3'b011
	} tcir_trig_t;
endpackage

// ===== design/tcir_irq_if.sv
// Carrier between the register bank and the interrupt status unit
`timescale 1ns/1ps
interface tcir_irq_if;
	logic [7:0] mask_main;
	logic [7:0] mask_tim;
	logic [7:0] mask_err;
	logic       rd_main;
	logic       rd_tim;
	logic       rd_err;
	logic       clr_all;
	logic [7:0] st_main;
	logic [7:0] st_tim;
	logic [7:0] st_err;
	logic       irq;
	modport bank (output mask_main, mask_tim, mask_err, rd_main, rd_tim, rd_err, clr_all,
		input st_main, st_tim, st_err, irq);
	modport stat (input mask_main, mask_tim, mask_err, rd_main, rd_tim, rd_err, clr_all,
		output st_main, st_tim, st_err, irq);
endinterface

// ===== design/tcir_irq_stat.sv
// Interrupt status registers with read-to-clear and the masked interrupt line
`timescale 1ns/1ps
module tcir_irq_stat (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic [5:0] main_evt_in,
	input  wire logic [7:0] tim_evt_in,
	input  wire logic [7:0] err_evt_in,
	tcir_irq_if.stat        bus
);
	import tcir_pkg::*;

	logic [5:0] main_st_r;
	logic       sum_tim_r;
	logic       sum_err_r;
	logic [7:0] tim_st_r;
	logic [7:0] err_st_r;
	logic       irq_r;
	logic [7:0] pend_main;
	logic [7:0] pend_tim;
	logic [7:0] pend_err;

	// ==========================================================
	// Status capture; a new event wins over a clearing read and over set-default,
	// so an event in the clearing cycle is never lost
	// [R16] main read clears
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			main_st_r <= ZERO_BYTE[5:0];
		end else if (bus.clr_all) begin
			main_st_r <= main_evt_in;
		end else begin
			main_st_r <= (bus.rd_main ? ZERO_BYTE[5:0] : main_st_r) | main_evt_in;
		end
	end

	// [R16] summary bits clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sum_tim_r <= 1'b0;
			sum_err_r <= 1'b0;
		end else if (bus.clr_all) begin
			sum_tim_r <= |tim_evt_in;
			sum_err_r <= |err_evt_in;
		end else begin
			sum_tim_r <= (sum_tim_r && !bus.rd_tim) || (|tim_evt_in);
			sum_err_r <= (sum_err_r && !bus.rd_err) || (|err_evt_in);
		end
	end

	// [R17] cleared by main read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tim_st_r <= ZERO_BYTE;
		end else if (bus.clr_all) begin
			tim_st_r <= tim_evt_in;
		end else begin
			tim_st_r <= (bus.rd_main ? ZERO_BYTE : tim_st_r) | tim_evt_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			err_st_r <= ZERO_BYTE;
		end else if (bus.clr_all) begin
			err_st_r <= err_evt_in;
		end else begin
			err_st_r <= (bus.rd_err ? ZERO_BYTE : err_st_r) | err_evt_in;
		end
	end

	assign bus.st_main = {main_st_r, sum_tim_r, sum_err_r};
	assign bus.st_tim  = tim_st_r;
	assign bus.st_err  = err_st_r;

	// ==========================================================
	// Per-bit masking; status still records masked events for polling
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_mask
			// [R14] mask blocks source
			assign pend_main[gi] = bus.st_main[gi] && !bus.mask_main[gi];
			assign pend_tim[gi]  = tim_st_r[gi] && !bus.mask_tim[gi];
			assign pend_err[gi]  = err_st_r[gi] && !bus.mask_err[gi];
		end
	endgenerate

	// Summary bits are not sources themselves; their detail bits are
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (|pend_main[7:MAIN_SRC_LSB]) || (|pend_tim) || (|pend_err);
		end
	end

	assign bus.irq = irq_r;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	a_main_read_clear: assert property ( // [R16]
		bus.rd_main && !bus.clr_all && main_evt_in == 6'h00 |=> main_st_r == 6'h00)
		else $error("main status not cleared by read");
	a_tim_main_clear: assert property ( // [R17]
		bus.rd_main && !bus.clr_all && tim_evt_in == 8'h00 |=> tim_st_r == 8'h00)
		else $error("timer status not cleared after main read");
	a_summary_holds: assert property ( // [R16]
		sum_tim_r && !bus.rd_tim && !bus.clr_all |=> sum_tim_r)
		else $error("timer summary bit cleared without its read");
	a_set_wins: assert property ( // [R16]
		(|tim_evt_in) |=> sum_tim_r && ((tim_st_r & $past(tim_evt_in)) != 8'h00))
		else $error("event lost against a clear");
	a_mask_blocks_irq: assert property ( // [R14]
		(bus.mask_tim == 8'hFF) && (bus.mask_err == 8'hFF) && (bus.mask_main[7:2] == 6'h3F)
		|=> !irq_r)
		else $error("interrupt raised while all sources masked");
	a_unmasked_irq: assert property ( // [R10]
		tim_st_r[5] && !bus.mask_tim[5] |=> irq_r)
		else $error("unmasked timer expiry did not raise interrupt");
endmodule

// ===== design/tcir_regs.sv
// Timer control, timeout and interrupt mask register bank, top level
// Notes on behaviour
// [R1] Trigger field bits 7:5: 000 command only, 001 end of receive, 010 start of receive.
// [R2] Trigger 011 starts at end of transmit; expiry then turns the field off.
// [R3] Trigger codes 100 to 111 give no automatic start source.
// [R4] Bit 0 picks no-response step: 64/fc clear, 4096/fc set.
// [R5] Bit 1 set selects the compliance mode of the no-response timer.
// [R6] Timeout is 16 bits, high byte 0x12, low byte 0x13, 8/fc steps.
// [R7] Timeout spans one step up to full count.
// [R8] Power-up and the set-default command reload all defaults.
// [R9] Main mask bits 7:2 block oscillator, level, rx start, rx end, tx end, collision.
// [R10] Timer mask bits 7:5 block command end, no-response and timer expiry.
// [R11] Timer mask bits 4:0 block field on, field off, collision, guard time, bit rate.
// [R12] Error mask bits 7:4 block CRC, parity, soft and hard framing errors.
// [R13] Error mask bits 3:0 block wake timer, amplitude, phase and capacitance wake-ups.
// [R14] A masked source never drives the interrupt; masks reset to zero.
// [R15] Unused control and main mask bits read zero and ignore writes.
// [R16] Main status read clears it except summary bits, cleared by their own reads.
// [R17] Timer status is cleared once main status has been read.
`timescale 1ns/1ps
module tcir_regs (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rst_n_in,
	input  wire logic [5:0]           reg_addr_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [7:0]           reg_wdata_in,
	input  wire logic                 set_default_in,
	input  wire logic [5:0]           main_evt_in,
	input  wire logic [7:0]           tim_evt_in,
	input  wire logic [7:0]           err_evt_in,
	output logic      [7:0]           reg_rdata_out,
	output logic                      irq_out,
	output tcir_pkg::tcir_trig_t      trig_src_out,
	output logic                      field_off_on_expiry_out,
	output logic                      nrt_step_long_out,
	output logic                      nrt_compliance_out,
	output logic      [15:0]          gp_timeout_out
);
	import tcir_pkg::*;

	logic       clr_all;
	logic [7:0] ctrl_r;
	logic [7:0] gp_hi_r;
	logic [7:0] gp_lo_r;
	logic [7:0] mask_main_r;
	logic [7:0] mask_tim_r;
	logic [7:0] mask_err_r;
	logic [7:0] rdata_r;
	logic [7:0] rd_mux;
	tcir_trig_t trig_r;
	tcir_trig_t trig_nxt;
	logic       field_off_r;
	logic       step_long_r;
	logic       compliance_r;
	logic [15:0] gp_count_r;
	logic [15:0] gp_raw;

	tcir_irq_if irq_bus ();

	// ==========================================================
	// Register writes
	// [R8] defaults on command
	assign clr_all = !rst_n_in || set_default_in;

	// [R15] unused bits dropped
	always_ff @(posedge clk_sys_in) begin
		if (clr_all) begin
			ctrl_r <= CTRL_RST;
		end else if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
			ctrl_r <= reg_wdata_in & CTRL_WMASK;
		end
	end

	// [R6] timeout byte pair
	always_ff @(posedge clk_sys_in) begin
		if (clr_all) begin
			gp_hi_r <= GP_RST;
			gp_lo_r <= GP_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == ADDR_GPHI) begin
				gp_hi_r <= reg_wdata_in;
			end
			if (reg_addr_in == ADDR_GPLO) begin
				gp_lo_r <= reg_wdata_in;
			end
		end
	end

	// [R9] main mask bits
	always_ff @(posedge clk_sys_in) begin
		if (clr_all) begin
			mask_main_r <= MASK_RST;
		end else if (reg_wr_in && reg_addr_in == ADDR_MMAI) begin
			mask_main_r <= reg_wdata_in & MMAI_WMASK;
		end
	end

	// [R10] [R11] [R12] [R13] full byte masks
	always_ff @(posedge clk_sys_in) begin
		if (clr_all) begin
			mask_tim_r <= MASK_RST;
			mask_err_r <= MASK_RST;
		end else if (reg_wr_in) begin
			if (reg_addr_in == ADDR_MTIM) begin
				mask_tim_r <= reg_wdata_in;
			end
			if (reg_addr_in == ADDR_MERR) begin
				mask_err_r <= reg_wdata_in;
			end
		end
	end

	// ==========================================================
	// Decoded timer controls
	// [R1] [R3] trigger decode
	always_comb begin
		case (ctrl_r[TRIG_MSB:TRIG_LSB])
			3'b000:  trig_nxt = TRIG_NONE;
			3'b001:  trig_nxt = TRIG_RX_END;
			3'b010:  trig_nxt = TRIG_RX_START;
			3'b011:  trig_nxt = TRIG_TX_END;
			default: trig_nxt = TRIG_NONE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			trig_r      <= TRIG_NONE;
			field_off_r <= 1'b0;
		end else begin
			trig_r      <= trig_nxt;
			// [R2] field off on expiry
			field_off_r <= (trig_nxt == TRIG_TX_END);
		end
	end

	// [R4] [R5] step and mode
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			step_long_r  <= 1'b0;
			compliance_r <= 1'b0;
		end else begin
			step_long_r  <= ctrl_r[NRT_STEP_BIT];
			compliance_r <= ctrl_r[NRT_MODE_BIT];
		end
	end

	// [R7] zero counts as one step
	assign gp_raw = {gp_hi_r, gp_lo_r};
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			gp_count_r <= GP_MIN_COUNT;
		end else begin
			gp_count_r <= (gp_raw == GP_ZERO) ? GP_MIN_COUNT : gp_raw;
		end
	end

	// ==========================================================
	// Interrupt status unit
	assign irq_bus.mask_main = mask_main_r;
	assign irq_bus.mask_tim  = mask_tim_r;
	assign irq_bus.mask_err  = mask_err_r;
	assign irq_bus.clr_all   = set_default_in;
	assign irq_bus.rd_main   = reg_rd_in && reg_addr_in == ADDR_SMAI;
	assign irq_bus.rd_tim    = reg_rd_in && reg_addr_in == ADDR_STIM;
	assign irq_bus.rd_err    = reg_rd_in && reg_addr_in == ADDR_SERR;

	tcir_irq_stat u_stat (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.main_evt_in (main_evt_in),
		.tim_evt_in  (tim_evt_in),
		.err_evt_in  (err_evt_in),
		.bus         (irq_bus.stat)
	);

	// ==========================================================
	// Read path; data is held only in the cycle after the read strobe
	always_comb begin
		case (reg_addr_in)
			ADDR_CTRL: rd_mux = ctrl_r;
			ADDR_GPHI: rd_mux = gp_hi_r;
			ADDR_GPLO: rd_mux = gp_lo_r;
			ADDR_MMAI: rd_mux = mask_main_r;
			ADDR_MTIM: rd_mux = mask_tim_r;
			ADDR_MERR: rd_mux = mask_err_r;
			ADDR_SMAI: rd_mux = irq_bus.st_main;
			ADDR_STIM: rd_mux = irq_bus.st_tim;
			ADDR_SERR: rd_mux = irq_bus.st_err;
			default:   rd_mux = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rdata_r <= ZERO_BYTE;
		end else begin
			rdata_r <= reg_rd_in ? rd_mux : ZERO_BYTE;
		end
	end

	assign reg_rdata_out           = rdata_r;
	assign irq_out                 = irq_bus.irq;
	assign trig_src_out            = trig_r;
	assign field_off_on_expiry_out = field_off_r;
	assign nrt_step_long_out       = step_long_r;
	assign nrt_compliance_out      = compliance_r;
	assign gp_timeout_out          = gp_count_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	a_ctrl_unused_zero: assert property ( // [R15]
		ctrl_r[4:2] == 3'b000 && mask_main_r[1:0] == 2'b00)
		else $error("unused control or mask bits set");
	a_trig_unused_none: assert property ( // [R3]
		ctrl_r[TRIG_MSB] |=> trig_src_out == TRIG_NONE)
		else $error("unused trigger code gave a source");
	a_trig_decode: assert property ( // [R1]
		ctrl_r[7:5] == 3'b001 |=> trig_src_out == TRIG_RX_END)
		else $error("end of receive trigger not decoded");
	a_field_off_sel: assert property ( // [R2]
		##1 field_off_on_expiry_out == ($past(ctrl_r[7:5]) == 3'b011))
		else $error("field off flag does not follow trigger 011");
	a_step_follows: assert property ( // [R4]
		reg_wr_in && reg_addr_in == ADDR_CTRL && !set_default_in
		|=> ##1 nrt_step_long_out == $past(reg_wdata_in[0], 2))
		else $error("step select did not follow write");
	a_mode_follows: assert property ( // [R5]
		reg_wr_in && reg_addr_in == ADDR_CTRL && !set_default_in
		|=> ##1 nrt_compliance_out == $past(reg_wdata_in[1], 2))
		else $error("compliance mode did not follow write");
	a_timeout_span: assert property ( // [R7]
		gp_timeout_out != 16'h0000)
		else $error("timeout shows zero steps");
	a_timeout_pair: assert property ( // [R6]
		gp_raw != 16'h0000 |=> gp_timeout_out == $past(gp_raw))
		else $error("timeout does not join high and low bytes");
	a_default_reload: assert property ( // [R8]
		set_default_in |=> ctrl_r == 8'h00 && mask_main_r == 8'h00 && mask_tim_r == 8'h00
		&& mask_err_r == 8'h00 && gp_hi_r == 8'h00 && gp_lo_r == 8'h00)
		else $error("set default did not reload registers");
	a_mask_err_block: assert property ( // [R12]
		mask_err_r == 8'hFF && mask_tim_r == 8'hFF && mask_main_r == 8'hFC |=> !irq_out)
		else $error("masked error source raised interrupt");
endmodule

// ===== verif/tcir_host_model.sv
// Host side model that drives the register port of the bank
`timescale 1ns/1ps
module tcir_host_model (
	input  wire logic       clk_sys_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic      [5:0] reg_addr_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic      [7:0] reg_wdata_out
);
	initial begin
		reg_addr_out  = 6'h3F;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		reg_wdata_out = 8'h00;
	end
	// ==========================================================
	// Bus cycles
	// Released address and data lines show the inverse of their last value and both strobes go low, so stale data never passes
	task automatic rel();
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		reg_addr_out  = ~reg_addr_out;
		reg_wdata_out = ~reg_wdata_out;
	endtask
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		#1;
		reg_addr_out  = a;
		reg_wdata_out = d;
		reg_wr_out    = 1'b1;
		@(posedge clk_sys_in);
		#1;
		rel();
	endtask
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		#1;
		reg_addr_out = a;
		reg_rd_out   = 1'b1;
		@(posedge clk_sys_in);
		#1;
		d = reg_rdata_in;
		rel();
	endtask
endmodule

// ===== verif/tcir_regs_tb_top.sv
// Self-checking testbench of the timer control and interrupt mask register bank
`timescale 1ns/1ps
module tcir_regs_tb_top;
	import tcir_pkg::*;
	logic        clk_sys_in;
	logic        rst_n_in;
	logic [5:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic        set_default;
	logic [5:0]  main_evt;
	logic [7:0]  tim_evt;
	logic [7:0]  err_evt;
	logic [7:0]  reg_rdata;
	logic        irq_out;
	tcir_trig_t  trig_src;
	logic        field_off;
	logic        step_long;
	logic        compliance;
	logic [15:0] gp_timeout;
	int          n_fail;
	int          cmp_count;
	logic [7:0]  rv;
	logic [7:0]  bv;
	logic [7:0]  lv;
	logic [5:0]  ma;
	int          g;
	tcir_regs uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
		.set_default_in(set_default), .main_evt_in(main_evt), .tim_evt_in(tim_evt),
		.err_evt_in(err_evt), .reg_rdata_out(reg_rdata), .irq_out(irq_out),
		.trig_src_out(trig_src), .field_off_on_expiry_out(field_off),
		.nrt_step_long_out(step_long), .nrt_compliance_out(compliance),
		.gp_timeout_out(gp_timeout));
	tcir_host_model host (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata),
		.reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
		.reg_wdata_out(reg_wdata));
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	// ==========================================================
	// Compare and stimulus tasks
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(input logic [5:0] a, input logic [7:0] e);
		host.rd_reg(a, rv);
		chk8($sformatf("reg %h", a), e, rv);
	endtask
	// Event bits are held for exactly one cycle, as pulses
	task automatic pulse(input logic [5:0] m, input logic [7:0] t, input logic [7:0] e);
		@(posedge clk_sys_in);
		#1;
		main_evt = m;
		tim_evt  = t;
		err_evt  = e;
		@(posedge clk_sys_in);
		#1;
		main_evt = 6'h00;
		tim_evt  = 8'h00;
		err_evt  = 8'h00;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		n_fail = 0;
		cmp_count = 0;
		rst_n_in = 1'b0;
		set_default = 1'b0;
		main_evt = 6'h00;
		tim_evt = 8'h00;
		err_evt = 8'h00;
		repeat (16) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		for (int a = 17; a < 23; a++) rchk(6'(a), 8'h00);
		chk16("timeout", 16'h0001, gp_timeout);
		chk8("irq", 8'h00, {7'h00, irq_out});
		// Every trigger code, with the spare bits written as ones
		for (int c = 0; c < 8; c++) begin
			host.wr_reg(ADDR_CTRL, {3'(c), 3'b111, 2'(c)});
			rchk(ADDR_CTRL, {3'(c), 3'b000, 2'(c)});
			chk8("trig", {5'h00, (c < 4) ? 3'(c) : 3'b000}, {5'h00, trig_src});
			chk8("field off", {7'h00, c == 3}, {7'h00, field_off});
			chk8("step", {7'h00, c[0]}, {7'h00, step_long});
			chk8("mode", {7'h00, c[1]}, {7'h00, compliance});
		end
		for (int k = 0; k < 4; k++) begin
			bv = (k == 0) ? 8'hFF : (k == 2) ? 8'hA5 : 8'h00;
			lv = (k == 0) ? 8'hFF : (k == 2) ? 8'h3C : 8'(k == 3);
			host.wr_reg(ADDR_GPHI, bv);
			host.wr_reg(ADDR_GPLO, lv);
			rchk(ADDR_GPHI, bv);
			rchk(ADDR_GPLO, lv);
			chk16("timeout", ({bv, lv} == 16'h0000) ? 16'h0001 : {bv, lv}, gp_timeout);
		end
		host.wr_reg(ADDR_GPHI, 8'h5A);
		rchk(ADDR_GPLO, 8'h01);
		chk16("timeout", 16'h5A01, gp_timeout);
		host.wr_reg(ADDR_MMAI, 8'hFF);
		rchk(ADDR_MMAI, 8'hFC);
		host.wr_reg(6'h20, 8'hFF);
		rchk(6'h20, 8'h00);
		// Each source once masked, then once enabled
		for (int i = 0; i < 22; i++) begin
			g = (i < 6) ? 0 : (i < 14) ? 1 : 2;
			bv = 8'h01 << ((g == 0) ? i + 2 : (g == 1) ? i - 6 : i - 14);
			ma = ADDR_MMAI + 6'(g);
			host.wr_reg(ma, bv);
			pulse((g == 0) ? bv[7:2] : 6'h00, (g == 1) ? bv : 8'h00, (g == 2) ? bv : 8'h00);
			repeat (2) @(posedge clk_sys_in);
			#1;
			chk8("irq masked", 8'h00, {7'h00, irq_out});
			if (g == 0) begin
				rchk(ADDR_SMAI, bv);
				rchk(ADDR_SMAI, 8'h00);
			end else if (g == 1) begin
				rchk(ADDR_STIM, bv);
				rchk(ADDR_SMAI, 8'h00);
				rchk(ADDR_STIM, 8'h00);
			end else begin
				rchk(ADDR_SMAI, 8'h01);
				rchk(ADDR_SERR, bv);
				rchk(ADDR_SMAI, 8'h00);
			end
			host.wr_reg(ma, 8'h00);
			pulse((g == 0) ? bv[7:2] : 6'h00, (g == 1) ? bv : 8'h00, (g == 2) ? bv : 8'h00);
			chk8("irq early", 8'h00, {7'h00, irq_out});
			@(posedge clk_sys_in);
			#1;
			chk8("irq on", 8'h01, {7'h00, irq_out});
			host.rd_reg(ADDR_STIM, rv);
			host.rd_reg(ADDR_SMAI, rv);
			host.rd_reg(ADDR_SERR, rv);
			@(posedge clk_sys_in);
			#1;
			chk8("irq off", 8'h00, {7'h00, irq_out});
		end
		// Set-default with registers programmed, every source masked and events held in status
		host.wr_reg(ADDR_CTRL, 8'h63);
		host.wr_reg(ADDR_GPHI, 8'h12);
		host.wr_reg(ADDR_MMAI, 8'hFF);
		host.wr_reg(ADDR_MTIM, 8'hFF);
		host.wr_reg(ADDR_MERR, 8'hFF);
		pulse(6'h3F, 8'hFF, 8'hFF);
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk8("irq all masked", 8'h00, {7'h00, irq_out});
		rchk(ADDR_SMAI, 8'hFF);
		set_default = 1'b1;
		@(posedge clk_sys_in);
		#1;
		set_default = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk8("irq", 8'h00, {7'h00, irq_out});
		chk8("trig", 8'h00, {5'h00, trig_src});
		chk16("timeout", 16'h0001, gp_timeout);
		chk8("field off", 8'h00, {7'h00, field_off});
		chk8("step", 8'h00, {7'h00, step_long});
		chk8("mode", 8'h00, {7'h00, compliance});
		for (int a = 17; a < 26; a++) rchk(6'(a), 8'h00);
		give_verdict();
	end
endmodule
